// [lsl_async_fifo.sv]
// shared constants of the serial link and its dual-clock word buffer
package lsl_pkg;
    // ------------------------------------------------------------------
    // lane layout
    // ------------------------------------------------------------------
    localparam int LANES         = 4;      // serial data lanes
    localparam int BITS_PER_LANE = 7;      // bit slots per clock period
    localparam int WORD_W        = 28;     // parallel word width
    localparam int FIFO_DEPTH    = 32;     // words buffered toward the link
    localparam logic [2:0] SLOT_FIRST = 3'h0;  // bit 0 slot
    localparam logic [2:0] SLOT_ONE   = 3'h1;  // slot after the reference
    localparam logic [2:0] SLOT_LAST  = 3'h6;  // bit 6 slot
    // forwarded clock over slots 0..6: high in 0..3, low in 4..6
    localparam logic [6:0] LINK_CLK_PATTERN = 7'h0F;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int REF_CLK_PERIOD_NS = 10;       // ref_clk_i period
    localparam int NS_PER_MS         = 1000000;
    localparam int NS_PER_US         = 1000;
    localparam int PLL_SETTLE_MS     = 10;       // lock settle, longest
    localparam int TX_PD_DELAY_NS    = 100;      // tx power-down, longest
    localparam int RX_PD_DELAY_US    = 1;        // rx power-down, longest
    localparam int PLL_SETTLE_CYC =
        PLL_SETTLE_MS * NS_PER_MS / REF_CLK_PERIOD_NS;
    localparam int TX_PD_CYC = TX_PD_DELAY_NS / REF_CLK_PERIOD_NS;
    localparam int RX_PD_CYC =
        RX_PD_DELAY_US * NS_PER_US / REF_CLK_PERIOD_NS;
endpackage

`timescale 1ns/1ps
// ----------------------------------------------------------------------
// dual-clock fifo, gray pointers, registered read data
// ----------------------------------------------------------------------
module lsl_async_fifo #(
    parameter int WIDTH = 28,
    parameter int DEPTH = 32
) (
    // write side
    input  wire logic             wr_clk_i,
    input  wire logic             wr_rst_i,
    input  wire logic             wr_valid_i,
    output logic                  wr_ready_o,
    input  wire logic [WIDTH-1:0] wr_data_i,
    // read side
    input  wire logic             rd_clk_i,
    input  wire logic             rd_rst_i,
    output logic                  rd_valid_o,
    input  wire logic             rd_ready_i,
    output logic      [WIDTH-1:0] rd_data_o
);
    // depth must be a power of two for the gray wrap to hold
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] PTR_ONE = {{AW{1'b0}}, 1'b1};

    logic [WIDTH-1:0] mem [DEPTH];          // storage
    logic [AW:0]      wbin;                 // write pointer, binary
    logic [AW:0]      wgray;                // write pointer, gray
    logic [AW:0]      rbin;                 // read pointer, binary
    logic [AW:0]      rgray;                // read pointer, gray
    logic [AW:0]      rgray_s1;             // read gray, first stage
    logic [AW:0]      rgray_s2;             // read gray in write domain
    logic [AW:0]      wgray_s1;             // write gray, first stage
    logic [AW:0]      wgray_s2;             // write gray in read domain

    wire [AW:0] next_wbin  = wbin + PTR_ONE;
    wire [AW:0] next_rbin  = rbin + PTR_ONE;
    wire        full       = wgray == {~rgray_s2[AW:AW-1], rgray_s2[AW-2:0]};
    wire        empty      = rgray == wgray_s2;
    wire        push       = wr_valid_i && !full;
    // pull a word when the output register is free or being taken
    wire        pull       = !empty && (!rd_valid_o || rd_ready_i);

    assign wr_ready_o = !full;

    // write domain: store and advance, sync read pointer
    always_ff @(posedge wr_clk_i) begin
        if (push) begin
            mem[wbin[AW-1:0]] <= wr_data_i;
        end
        if (wr_rst_i) begin
            wbin     <= '0;
            wgray    <= '0;
            rgray_s1 <= '0;
            rgray_s2 <= '0;
        end else begin
            if (push) begin
                wbin  <= next_wbin;
                wgray <= next_wbin ^ (next_wbin >> 1);
            end
            rgray_s1 <= rgray;
            rgray_s2 <= rgray_s1;
        end
    end

    // read domain: output register, sync write pointer
    always_ff @(posedge rd_clk_i) begin
        if (rd_rst_i) begin
            rbin       <= '0;
            rgray      <= '0;
            wgray_s1   <= '0;
            wgray_s2   <= '0;
            rd_valid_o <= 1'b0;
            rd_data_o  <= '0;
        end else begin
            wgray_s1 <= wgray;
            wgray_s2 <= wgray_s1;
            if (pull) begin
                rd_data_o  <= mem[rbin[AW-1:0]];
                rd_valid_o <= 1'b1;
                rbin       <= next_rbin;
                rgray      <= next_rbin ^ (next_rbin >> 1);
            end else if (rd_ready_i) begin
                rd_valid_o <= 1'b0;
            end
        end
    end
endmodule

// [lsl_far_end.sv]
// far-end model: loops the transmit pins back onto the receive pins
`timescale 1ns/1ps
module lsl_far_end (
    // bit clock
    input  wire logic       ref_clk_i,
    // transmit pins on the cable
    input  wire logic [3:0] lane_i,
    input  wire logic [3:0] lane_oe_n_i,
    input  wire logic       fwd_clk_i,
    input  wire logic       fwd_oe_n_i,
    // receive pins fed back
    output logic      [3:0] lane_o,
    output logic            fwd_clk_o
);
    // known start level, but the first edge samples X enables, so a pair floated in reset shows X
    logic [3:0] held     = 4'h0;  // level seen on the lanes last cycle
    logic       held_clk = 1'b0;  // level seen on the clock pair last cycle
    // remember the last level so a released pair can be shown toggling
    always_ff @(posedge ref_clk_i) begin
        held     <= lane_o;
        held_clk <= fwd_clk_o;
    end
    // a floating pair flips every cycle, never keeps stale data
    assign lane_o    = (lane_i & ~lane_oe_n_i) | (~held & lane_oe_n_i);
    assign fwd_clk_o = fwd_oe_n_i ? ~held_clk : fwd_clk_i;
endmodule

// [lsl_serdes_link.sv]
// serial link pair: 28-bit word to four 7-bit lanes and back
`timescale 1ns/1ps
// Functional notes
// - seven evenly spaced bits per lane per period
// - receiver samples seven bits after frame reference
// - transmitter outputs invalid until settle time passes
// - receiver outputs invalid until settle time passes
// - transmitter high impedance within 100 ns
// - receiver outputs low within one microsecond
// - latency one period out, two back
// - regenerated receive clock near even duty
// - capture on rising edge, present on rising
// - tx power-down low floats all serial outputs
// - rx power-down low forces parallel outputs low
module lsl_serdes_link #(
    parameter int SETTLE_CYCLES = lsl_pkg::PLL_SETTLE_CYC,
    parameter int FIFO_DEPTH    = lsl_pkg::FIFO_DEPTH
) (
    // clocks and reset
    input  wire logic                        ref_clk_i,
    input  wire logic                        reset_i,
    input  wire logic                        tx_parallel_clock_i,
    // parallel source, tx_parallel_clock_i domain
    input  wire logic [lsl_pkg::WORD_W-1:0]  parallel_tx_input_i,
    input  wire logic                        tx_valid_i,
    output logic                             tx_ready_o,
    // transmit pins
    input  wire logic                        tx_power_down_n_i,
    output logic [lsl_pkg::LANES-1:0]        serial_data_lane_out_o,
    output logic [lsl_pkg::LANES-1:0]        serial_data_lane_oe_n_o,
    output logic                             forwarded_link_clock_o,
    output logic                             forwarded_link_clock_oe_n_o,
    output logic                             tx_locked_o,
    // receive pins
    input  wire logic                        rx_power_down_n_i,
    input  wire logic [lsl_pkg::LANES-1:0]   serial_data_lane_in_i,
    input  wire logic                        link_clock_in_i,
    output logic [lsl_pkg::WORD_W-1:0]       parallel_rx_output_o,
    output logic                             rx_parallel_clock_o,
    output logic                             rx_locked_o
);
    // ------------------------------------------------------------------
    // local constants
    // ------------------------------------------------------------------
    localparam int LN = lsl_pkg::LANES;          // lane count
    localparam int BL = lsl_pkg::BITS_PER_LANE;  // bits per lane
    localparam int WW = lsl_pkg::WORD_W;         // word width
    localparam int SW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SW-1:0] SETTLE_END = SW'(SETTLE_CYCLES);
    localparam logic [SW-1:0] SETTLE_ONE = SW'(1);
    localparam logic [2:0] SLOT_INC = 3'h1;

    // ------------------------------------------------------------------
    // link-domain reset and word capture
    // ------------------------------------------------------------------
    logic link_rst_s1;                    // reset, first stage
    logic link_rst;                       // reset in link domain

    // reset_i belongs to ref_clk_i; bring it over before use
    always_ff @(posedge tx_parallel_clock_i) begin
        link_rst_s1 <= reset_i;
        link_rst    <= link_rst_s1;
    end

    logic          fifo_rd_valid;         // next word is waiting
    logic          fifo_rd_ready;         // word taken at frame end
    logic [WW-1:0] tx_word;               // word at the fifo head

    // words are written on the rising edge of the source clock; the
    // frame rate here is fixed by ref_clk_i, so a source clock inside
    // its legal range can outrun it and ready then stalls the source
    lsl_async_fifo #(
        .WIDTH (WW),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .wr_clk_i   (tx_parallel_clock_i),
        .wr_rst_i   (link_rst),
        .wr_valid_i (tx_valid_i),
        .wr_ready_o (tx_ready_o),
        .wr_data_i  (parallel_tx_input_i),
        .rd_clk_i   (ref_clk_i),
        .rd_rst_i   (reset_i),
        .rd_valid_o (fifo_rd_valid),
        .rd_ready_i (fifo_rd_ready),
        .rd_data_o  (tx_word)
    );

    // ------------------------------------------------------------------
    // transmit power-down and settle
    // ------------------------------------------------------------------
    logic          tx_pd_s1;              // power-down pin, first stage
    logic          tx_pd_s2;              // synced, high means running
    logic [SW-1:0] tx_settle;             // cycles since release
    logic          tx_locked;             // settle time has passed
    logic          tx_oe_n;               // serial pins released

    always_ff @(posedge ref_clk_i) begin
        tx_pd_s1 <= tx_power_down_n_i;
        tx_pd_s2 <= tx_pd_s1;
    end

    // settle counter restarts on every power-down
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !tx_pd_s2) begin
            tx_settle <= '0;
            tx_locked <= 1'b0;
        end else if (tx_settle != SETTLE_END) begin
            tx_settle <= tx_settle + SETTLE_ONE;
        end else begin
            tx_locked <= 1'b1;
        end
    end

    // enable follows the synced pin, three edges from the pin change
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            tx_oe_n <= 1'b1;
        end else begin
            tx_oe_n <= !tx_pd_s2;
        end
    end

    assign serial_data_lane_oe_n_o     = {LN{tx_oe_n}};
    assign forwarded_link_clock_oe_n_o = tx_oe_n;
    assign tx_locked_o                 = tx_locked;

    // ------------------------------------------------------------------
    // transmit slot counter and forwarded clock
    // ------------------------------------------------------------------
    logic [2:0] tx_slot;                  // bit slot now on the lanes
    logic       fwd_clk;                  // forwarded clock register

    wire        tx_frame_end = tx_slot == lsl_pkg::SLOT_LAST;
    wire [2:0]  next_tx_slot = tx_frame_end ? lsl_pkg::SLOT_FIRST
                                            : 3'(tx_slot + SLOT_INC);

    // free-running slot count; one frame is seven ref clock cycles
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            tx_slot <= lsl_pkg::SLOT_FIRST;
        end else begin
            tx_slot <= next_tx_slot;
        end
    end

    // clock pattern is prepared for the slot of the next cycle
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            fwd_clk <= 1'b0;
        end else begin
            fwd_clk <= tx_locked &&
                       lsl_pkg::LINK_CLK_PATTERN[next_tx_slot];
        end
    end

    assign forwarded_link_clock_o = fwd_clk;
    // a word leaves the fifo only at a frame boundary once settled
    assign fifo_rd_ready = tx_locked && tx_frame_end;

    // ------------------------------------------------------------------
    // transmit lane shifters
    // ------------------------------------------------------------------
    logic [BL-1:0] tx_shift      [LN];    // per-lane shift register
    logic [BL-1:0] next_tx_shift [LN];    // their next values

    for (genvar l = 0; l < LN; l++) begin : g_tx_lane
        // lane l carries word bits l*7 .. l*7+6, bit 0 first
        assign next_tx_shift[l] =
            !tx_locked    ? '0 :
            tx_frame_end  ? (fifo_rd_valid ? tx_word[l*BL +: BL] : '0) :
                            {1'b0, tx_shift[l][BL-1:1]};

        // empty fifo sends an all-zero frame rather than stale data
        always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
                tx_shift[l] <= '0;
            end else begin
                tx_shift[l] <= next_tx_shift[l];
            end
        end

        assign serial_data_lane_out_o[l] = tx_shift[l][0];
    end

    // ------------------------------------------------------------------
    // receive pin synchronisers
    // ------------------------------------------------------------------
    logic          rx_pd_s1;              // power-down, first stage
    logic          rx_pd_s2;              // synced, high means running
    logic [LN-1:0] rx_lane_s1;            // lanes, first stage
    logic [LN-1:0] rx_lane_s2;            // lanes, synced
    logic          rx_clk_s1;             // link clock, first stage
    logic          rx_clk_s2;             // link clock, synced
    logic          rx_clk_prev;           // synced clock one cycle back

    // data and clock share the same two stages, so skew is kept
    always_ff @(posedge ref_clk_i) begin
        rx_pd_s1    <= rx_power_down_n_i;
        rx_pd_s2    <= rx_pd_s1;
        rx_lane_s1  <= serial_data_lane_in_i;
        rx_lane_s2  <= rx_lane_s1;
        rx_clk_s1   <= link_clock_in_i;
        rx_clk_s2   <= rx_clk_s1;
        rx_clk_prev <= rx_clk_s2;
    end

    // ------------------------------------------------------------------
    // receive framing and settle
    // ------------------------------------------------------------------
    logic [2:0]    rx_slot;               // expected slot without edge
    logic          rx_seen;               // link clock has appeared
    logic [SW-1:0] rx_settle;             // cycles since clock seen
    logic          rx_locked;             // settle time has passed

    // rising edge of the link clock is the bit 0 reference
    wire       frame_ref    = rx_clk_s2 && !rx_clk_prev;
    wire [2:0] rx_idx       = frame_ref ? lsl_pkg::SLOT_FIRST : rx_slot;
    wire       rx_word_done = rx_idx == lsl_pkg::SLOT_LAST;
    wire       rx_ok        = rx_pd_s2 && rx_locked;
    wire [2:0] next_rx_slot = frame_ref ? lsl_pkg::SLOT_ONE :
                              rx_word_done ? lsl_pkg::SLOT_FIRST :
                              3'(rx_slot + SLOT_INC);

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rx_slot <= lsl_pkg::SLOT_FIRST;
        end else begin
            rx_slot <= next_rx_slot;
        end
    end

    // settle runs once the link clock is seen and power is up
    always_ff @(posedge ref_clk_i) begin
        if (reset_i || !rx_pd_s2) begin
            rx_seen   <= 1'b0;
            rx_settle <= '0;
            rx_locked <= 1'b0;
        end else begin
            rx_seen <= rx_seen || frame_ref;
            if (rx_seen && rx_settle != SETTLE_END) begin
                rx_settle <= rx_settle + SETTLE_ONE;
            end
            rx_locked <= rx_settle == SETTLE_END;
        end
    end

    assign rx_locked_o = rx_locked;

    // ------------------------------------------------------------------
    // receive lane shifters and output stages
    // ------------------------------------------------------------------
    logic [BL-1:0] rx_shift      [LN];    // per-lane sample history
    logic [BL-1:0] next_rx_shift [LN];    // with this cycle's sample
    logic [WW-1:0] rx_word_asm;           // word if this is bit 6
    logic [WW-1:0] rx_word1;              // first frame stage
    logic [WW-1:0] rx_out;                // output register
    logic          rx_pclk;               // regenerated clock register

    for (genvar l = 0; l < LN; l++) begin : g_rx_lane
        // one sample per slot, mid-bit after the two-stage delay
        assign next_rx_shift[l] = {rx_lane_s2[l], rx_shift[l][BL-1:1]};
        // reverse of the transmit grouping
        assign rx_word_asm[l*BL +: BL] = next_rx_shift[l];

        always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
                rx_shift[l] <= '0;
            end else begin
                rx_shift[l] <= next_rx_shift[l];
            end
        end
    end

    // two frame stages; outputs forced low when off or unsettled
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rx_word1 <= '0;
            rx_out   <= '0;
        end else if (!rx_ok) begin
            rx_out   <= '0;
        end else if (rx_word_done) begin
            rx_word1 <= rx_word_asm;
            rx_out   <= rx_word1;
        end
    end

    // clock rises one cycle after new data: data is set up before it
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rx_pclk <= 1'b0;
        end else begin
            rx_pclk <= rx_ok &&
                       lsl_pkg::LINK_CLK_PATTERN[rx_idx];
        end
    end

    assign parallel_rx_output_o = rx_out;
    assign rx_parallel_clock_o  = rx_pclk;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);
    localparam int TX_PD_MAX = lsl_pkg::TX_PD_CYC;
    a_tx_pd_delay: assert property (
        $fell(tx_power_down_n_i) ##1 !tx_power_down_n_i[*2]
        |-> ##[0:TX_PD_MAX] (&serial_data_lane_oe_n_o))
        else $error("tx pins not floated in time after power-down");

    a_tx_pd_float: assert property (
        !tx_pd_s2 |=> (&serial_data_lane_oe_n_o) &&
                      forwarded_link_clock_oe_n_o)
        else $error("tx pins driven during power-down");

    a_tx_settle_quiet: assert property (
        !tx_locked_o |=> serial_data_lane_out_o == '0 &&
                         !forwarded_link_clock_o)
        else $error("tx lanes active before settle");

    a_tx_lane_order: assert property (
        tx_locked_o && tx_frame_end && fifo_rd_valid
        |=> (serial_data_lane_out_o[0] == $past(tx_word[0]))
        ##1 (serial_data_lane_out_o[0] == $past(tx_word[1], 2)))
        else $error("tx lane 0 bit order wrong");

    a_fwd_clk_pattern: assert property (
        $past(tx_locked_o) |->
        forwarded_link_clock_o == lsl_pkg::LINK_CLK_PATTERN[tx_slot])
        else $error("forwarded clock pattern wrong for slot");

    a_rx_pd_low: assert property (
        !rx_pd_s2 |=> parallel_rx_output_o == '0 && !rx_parallel_clock_o)
        else $error("rx outputs not low in power-down");

    a_rx_pd_delay: assert property (
        !rx_power_down_n_i[*4] |-> parallel_rx_output_o == '0)
        else $error("rx outputs not low soon after power-down");

    a_rx_settle_low: assert property (
        !rx_locked_o |=> parallel_rx_output_o == '0)
        else $error("rx outputs active before settle");

    a_rx_clk_duty: assert property (
        rx_ok && frame_ref ##1 (rx_ok && !frame_ref) [*4]
        |-> $past(rx_parallel_clock_o, 3) && $past(rx_parallel_clock_o, 2)
        && $past(rx_parallel_clock_o) && rx_parallel_clock_o
        ##1 !rx_parallel_clock_o)
        else $error("rx clock high time not four cycles");

    a_rx_two_frame: assert property (
        rx_ok && rx_word_done ##1 rx_ok [*6] ##1 (rx_ok && rx_word_done)
        |=> parallel_rx_output_o == $past(rx_word_asm, 8))
        else $error("rx word not delivered two frames later");

    c_tx_locked: cover property ($rose(tx_locked_o));
    c_rx_locked: cover property ($rose(rx_locked_o));
    c_rx_word:   cover property (rx_ok && rx_word_done &&
                                 rx_word_asm != '0);
    c_fifo_full: cover property (@(posedge tx_parallel_clock_i)
                                 disable iff (link_rst) !tx_ready_o);
endmodule

// [tb.sv]
// bench for the serial link pair with a loopback far end
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic        ref_clk_i = 1'b0;  // 100 MHz bit clock
    logic        tx_clk    = 1'b0;  // 48 ns source word clock
    logic        reset_i   = 1'b1;
    logic [27:0] tx_word   = 28'h0;
    logic        tx_valid  = 1'b0;
    logic        tx_pd_n   = 1'b1;  // transmit power-down, active low
    logic        rx_pd_n   = 1'b1;  // receive power-down, active low
    logic        saw_full  = 1'b0;  // source was held off at least once
    logic [6:0]  got;
    logic        prev;
    wire  [27:0] rx_word;
    wire  [3:0]  lanes, lanes_oe_n, lb_lanes;
    wire         tx_ready, tx_lock, rx_lock, rx_clk, fwd, fwd_oe_n, lb_clk;
    int          num_errors = 0;
    int          num_checks = 0;
    int          n;
    logic [27:0] expq[$];           // words sent but not yet seen back
    always #5 ref_clk_i = ~ref_clk_i;
    always #24 tx_clk = ~tx_clk;
    // ------------------------------------------------------------------
    // design and far end
    // ------------------------------------------------------------------
    lsl_serdes_link #(.SETTLE_CYCLES(20), .FIFO_DEPTH(32)) dut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .tx_parallel_clock_i(tx_clk), .parallel_tx_input_i(tx_word),
        .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
        .tx_power_down_n_i(tx_pd_n), .serial_data_lane_out_o(lanes),
        .serial_data_lane_oe_n_o(lanes_oe_n), .forwarded_link_clock_o(fwd),
        .forwarded_link_clock_oe_n_o(fwd_oe_n), .tx_locked_o(tx_lock),
        .rx_power_down_n_i(rx_pd_n), .serial_data_lane_in_i(lb_lanes),
        .link_clock_in_i(lb_clk), .parallel_rx_output_o(rx_word),
        .rx_parallel_clock_o(rx_clk), .rx_locked_o(rx_lock));
    lsl_far_end far (.ref_clk_i(ref_clk_i), .lane_i(lanes),
        .lane_oe_n_i(lanes_oe_n), .fwd_clk_i(fwd), .fwd_oe_n_i(fwd_oe_n),
        .lane_o(lb_lanes), .fwd_clk_o(lb_clk));
    // ------------------------------------------------------------------
    // checking and ending
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [27:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // a wait that ran out counts as a mismatch and ends the run
    task automatic bound(input int cnt, lim, input string what);
        if (cnt >= lim) begin
            check(what, 28'h1, 28'h0);
            conclude();
        end
    endtask
    // every regenerated clock edge with data must match the next word
    always @(posedge rx_clk) begin
        if (rx_word !== 28'h0 && expq.size() > 0)
            check("rx word", rx_word, expq.pop_front());
    end
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // lock is still low ten cycles after reset, then comes up within 200 cycles
    task automatic t_lock();
        repeat (10) @(posedge ref_clk_i);
        check("tx lock early", {27'h0, tx_lock}, 28'h0);
        check("rx lock early", {27'h0, rx_lock}, 28'h0);
        for (n = 0; n < 200 && !(tx_lock === 1'b1 && rx_lock === 1'b1); n++)
            @(posedge ref_clk_i);
        bound(n, 200, "lock");
    endtask
    // forwarded clock repeats high four slots, low three
    task automatic t_pattern();
        prev = 1'b1;
        for (n = 0; n < 20 && !(fwd === 1'b1 && prev === 1'b0); n++) begin
            prev = fwd;
            @(posedge ref_clk_i);
        end
        bound(n, 20, "clock edge");
        for (int k = 0; k < 7; k++) begin
            got[k] = fwd;
            @(posedge ref_clk_i);
        end
        check("fwd pattern", {21'h0, got}, 28'h000000F);
        check("lane enables", {24'h0, lanes_oe_n}, 28'h0);
    endtask
    // source outruns the link until refused, then the buffer drains
    task automatic t_stream();
        for (int i = 0; i < 140; i++) begin
            tx_word  <= 28'h9E3779B * (i + 1);
            tx_valid <= 1'b1;
            for (n = 0; n < 50; n++) begin
                @(posedge tx_clk);
                if (tx_ready === 1'b1)
                    break;
                saw_full = 1'b1;
            end
            bound(n, 50, "ready");
            expq.push_back(28'h9E3779B * (i + 1));
        end
        tx_valid <= 1'b0;
        for (n = 0; n < 5000 && expq.size() > 0; n++)
            @(posedge ref_clk_i);
        bound(n, 5000, "drain");
        check("held off", {27'h0, saw_full}, 28'h1);
    endtask
    // transmit power-down floats every pair within 100 ns
    task automatic t_tx_pd();
        tx_pd_n <= 1'b0;
        for (n = 0; n < 10 && !(&lanes_oe_n === 1'b1 && fwd_oe_n === 1'b1);
             n++)
            @(posedge ref_clk_i);
        bound(n, 10, "tx float");
        tx_pd_n <= 1'b1;
        for (n = 0; n < 200 && tx_lock !== 1'b1; n++)
            @(posedge ref_clk_i);
        bound(n, 200, "tx relock");
    endtask
    // receive power-down drives the outputs low within a microsecond
    task automatic t_rx_pd();
        @(posedge tx_clk);
        tx_word  <= 28'hFFFFFFF;
        tx_valid <= 1'b1;
        repeat (60) @(posedge ref_clk_i);
        check("ones word", rx_word, 28'hFFFFFFF);
        rx_pd_n <= 1'b0;
        for (n = 0; n < 100 && !(rx_word === 28'h0 && rx_clk === 1'b0); n++)
            @(posedge ref_clk_i);
        bound(n, 100, "rx low");
        repeat (20) @(posedge ref_clk_i);
        check("rx held low", rx_word, 28'h0);
    endtask
    // ------------------------------------------------------------------
    // main sequence: reset spans enough source edges for the buffer too
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge tx_clk);
        @(posedge ref_clk_i);
        reset_i <= 1'b0;
        t_lock();
        t_pattern();
        t_stream();
        t_tx_pd();
        t_rx_pd();
        conclude();
    end
endmodule
